//--- tcs_scheduler.sv
`timescale 1ns/1ns
module tcs_scheduler #(
    parameter int CONV_CYC = tcs_pkg::CONV_CYCLES,
    parameter int INT01_CYC = tcs_pkg::INTERVAL_01_CYCLES,
    parameter int INT10_CYC = tcs_pkg::INTERVAL_10_CYCLES,
    parameter int INT11_CYC = tcs_pkg::INTERVAL_11_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire tcs_pkg::tcs_req_s req,
    output logic [7:0] rdata,
    output logic conv_start,
    output logic [2:0] conv_chan,
    output logic busy,
    output logic standby,
    output logic remote1_ext_res,
    output logic remote2_ext_res
);
    localparam int W = tcs_pkg::TMR_W;

    function automatic logic [2:0] first_set(input logic [4:0] m);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = 4; i >= 0; i--) begin
            if (m[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction : first_set

    function automatic logic [W-1:0] interval_len(input logic [1:0] code);
        logic [W-1:0] len;
        unique case (code)
            2'h1: len = W'(INT01_CYC);
            2'h2: len = W'(INT10_CYC);
            2'h3: len = W'(INT11_CYC);
            default: len = '0;
        endcase
        return len;
    endfunction : interval_len

    function automatic logic filt_on(input logic [1:0] mode);
        return mode != tcs_pkg::FILT_OFF;
    endfunction : filt_on

    // Register group
    logic [1:0] rate_select_r, rate_select_nxt;
    logic [4:0] chan_en_r, chan_en_nxt;
    logic [1:0] remote2_filter_mode_r, remote2_filter_mode_nxt;
    logic [1:0] remote1_filter_mode_r, remote1_filter_mode_nxt;
    logic standby_ctrl_r, standby_ctrl_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic trig;

    always_comb begin
        rate_select_nxt = rate_select_r;
        chan_en_nxt = chan_en_r;
        remote2_filter_mode_nxt = remote2_filter_mode_r;
        remote1_filter_mode_nxt = remote1_filter_mode_r;
        standby_ctrl_nxt = standby_ctrl_r;
        rdata_nxt = rdata_r;
        // Trigger data is dropped here, only the write event survives
        trig = req.wr && (req.addr == tcs_pkg::ADDR_TRIGGER);
        if (req.wr) begin
            unique case (req.addr)
                tcs_pkg::ADDR_CONFIG:
                    standby_ctrl_nxt = req.wdata[tcs_pkg::STANDBY_BIT];
                tcs_pkg::ADDR_RATE: rate_select_nxt = req.wdata[1:0];
                tcs_pkg::ADDR_CHAN_EN: chan_en_nxt = req.wdata[4:0];
                tcs_pkg::ADDR_FILTER: begin
                    remote2_filter_mode_nxt = req.wdata[3:2];
                    remote1_filter_mode_nxt = req.wdata[1:0];
                end
                default: ;
            endcase
        end
        if (req.rd) begin
            unique case (req.addr)
                tcs_pkg::ADDR_CONFIG:
                    rdata_nxt = {1'b0, standby_ctrl_r, 6'h00};
                tcs_pkg::ADDR_RATE: rdata_nxt = {6'h00, rate_select_r};
                tcs_pkg::ADDR_CHAN_EN: rdata_nxt = {3'h0, chan_en_r};
                tcs_pkg::ADDR_FILTER:
                    rdata_nxt = {4'h0, remote2_filter_mode_r,
                                 remote1_filter_mode_r};
                // Trigger and unmapped locations read as zero
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rate_select_r <= tcs_pkg::RATE_RESET;
            chan_en_r <= tcs_pkg::CHAN_EN_RESET;
            remote2_filter_mode_r <= tcs_pkg::FILTER_RESET[3:2];
            remote1_filter_mode_r <= tcs_pkg::FILTER_RESET[1:0];
            standby_ctrl_r <= tcs_pkg::STANDBY_RESET;
            rdata_r <= 8'h00;
        end else if (ce) begin
            rate_select_r <= rate_select_nxt;
            chan_en_r <= chan_en_nxt;
            remote2_filter_mode_r <= remote2_filter_mode_nxt;
            remote1_filter_mode_r <= remote1_filter_mode_nxt;
            standby_ctrl_r <= standby_ctrl_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Sequencer group
    tcs_pkg::tcs_state_e state_r, state_nxt;
    logic [4:0] pend_r, pend_nxt;
    logic [W-1:0] conv_tmr_r, conv_tmr_nxt;
    logic [W-1:0] int_tmr_r, int_tmr_nxt;
    logic start_r, start_nxt;
    logic [2:0] chan_r, chan_nxt;
    logic single_r, single_nxt;
    logic pass_go;

    always_comb begin
        state_nxt = state_r;
        pend_nxt = pend_r;
        conv_tmr_nxt = conv_tmr_r;
        int_tmr_nxt = int_tmr_r + W'(1);
        start_nxt = 1'b0;
        chan_nxt = chan_r;
        single_nxt = single_r;
        pass_go = 1'b0;
        unique case (state_r)
            tcs_pkg::ST_IDLE: begin
                int_tmr_nxt = '0;
                if (!standby_ctrl_r) begin
                    pass_go = 1'b1;
                    single_nxt = 1'b0;
                end else if (trig) begin
                    pass_go = 1'b1;
                    single_nxt = 1'b1;
                end
            end
            tcs_pkg::ST_CONV: begin
                if (conv_tmr_r != '0) begin
                    conv_tmr_nxt = conv_tmr_r - W'(1);
                // Skipped channels cost no time
                end else if (pend_r != 5'h00) begin
                    chan_nxt = first_set(pend_r);
                    pend_nxt = pend_r & ~(5'h01 << first_set(pend_r));
                    start_nxt = 1'b1;
                    conv_tmr_nxt = W'(CONV_CYC - 1);
                end else if (single_r || standby_ctrl_r) begin
                    state_nxt = tcs_pkg::ST_IDLE;
                    single_nxt = 1'b0;
                end else if (rate_select_r == tcs_pkg::RATE_CONT) begin
                    pass_go = 1'b1;
                    int_tmr_nxt = '0;
                end else begin
                    state_nxt = tcs_pkg::ST_WAIT;
                end
            end
            tcs_pkg::ST_WAIT: begin
                // Interval runs from pass start, so fewer channels wait longer
                if (standby_ctrl_r) begin
                    state_nxt = tcs_pkg::ST_IDLE;
                    // Trigger landing as standby begins must not be lost
                    if (trig) begin
                        pass_go = 1'b1;
                        single_nxt = 1'b1;
                    end
                end else if (int_tmr_r + W'(1) >=
                             interval_len(rate_select_r)) begin
                    pass_go = 1'b1;
                    int_tmr_nxt = '0;
                end
            end
            default: state_nxt = tcs_pkg::ST_IDLE;
        endcase
        // A trigger outside standby falls through with no effect
        if (pass_go) begin
            state_nxt = tcs_pkg::ST_CONV;
            pend_nxt = chan_en_r;
            conv_tmr_nxt = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= tcs_pkg::ST_IDLE;
            pend_r <= 5'h00;
            conv_tmr_r <= '0;
            int_tmr_r <= '0;
            start_r <= 1'b0;
            chan_r <= 3'h0;
            single_r <= 1'b0;
        end else if (ce) begin
            state_r <= state_nxt;
            pend_r <= pend_nxt;
            conv_tmr_r <= conv_tmr_nxt;
            int_tmr_r <= int_tmr_nxt;
            start_r <= start_nxt;
            chan_r <= chan_nxt;
            single_r <= single_nxt;
        end
    end

    // Status outputs, registered so they stay glitch free at the pins
    logic busy_r, standby_r, r1x_r, r2x_r;
    logic busy_nxt, standby_nxt, r1x_nxt, r2x_nxt;

    always_comb begin
        busy_nxt = state_nxt == tcs_pkg::ST_CONV;
        standby_nxt = standby_ctrl_nxt;
        r1x_nxt = filt_on(remote1_filter_mode_nxt);
        r2x_nxt = filt_on(remote2_filter_mode_nxt);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            busy_r <= 1'b0;
            standby_r <= tcs_pkg::STANDBY_RESET;
            r1x_r <= filt_on(tcs_pkg::FILTER_RESET[1:0]);
            r2x_r <= filt_on(tcs_pkg::FILTER_RESET[3:2]);
        end else if (ce) begin
            busy_r <= busy_nxt;
            standby_r <= standby_nxt;
            r1x_r <= r1x_nxt;
            r2x_r <= r2x_nxt;
        end
    end

    assign rdata = rdata_r;
    assign conv_start = start_r;
    assign conv_chan = chan_r;
    assign busy = busy_r;
    assign standby = standby_r;
    assign remote1_ext_res = r1x_r;
    assign remote2_ext_res = r2x_r;
endmodule : tcs_scheduler

//--- tcs_pkg.sv
// Operation
// - Each rate interval converts every enabled channel in turn, then idles.
// - Rate code 00 runs passes back to back with no standby time inserted.
// - Codes 01, 10 and 11 give 0.364 s, 1 s and 2.5 s; reset code is 10.
// - Unused upper bits of rate, enable and filter registers read as zero.
// - Disabled channels are skipped, so continuous passes get shorter.
// - Non-continuous rates pad with standby so the interval stays fixed.
// - Enable bits 4..1 are remotes 4..1, bit 0 is local; reset value 0x1F.
// - The local channel is converted only while enable bit 0 is one.
// - Remote 2 filter at bits 3..2: 00 off, 01 basic, 11 enhanced.
// - Remote 1 filter at bits 1..0, same coding; both reset to enhanced.
// - A trigger write in standby starts exactly one pass over enabled ones; the code ignores one written during ST_CONV.
// - The trigger location is write-only and its data is not kept.
// - Configuration bit 6 is standby: one halts periodic conversion.
// - An enabled filter adds the 1/16 and 1/32 degree bits, else zero.
package tcs_pkg;
    localparam logic [7:0] ADDR_CONFIG = 8'h03;
    localparam logic [7:0] ADDR_RATE = 8'h04;
    localparam logic [7:0] ADDR_CHAN_EN = 8'h05;
    localparam logic [7:0] ADDR_FILTER = 8'h06;
    localparam logic [7:0] ADDR_TRIGGER = 8'h0F;
    localparam int STANDBY_BIT = 6;
    localparam logic [1:0] RATE_RESET = 2'h2;
    localparam logic [4:0] CHAN_EN_RESET = 5'h1F;
    localparam logic [3:0] FILTER_RESET = 4'hF;
    localparam logic STANDBY_RESET = 1'b0;
    localparam logic [1:0] RATE_CONT = 2'h0;
    localparam logic [1:0] FILT_OFF = 2'h0;
    localparam int CLK_KHZ = 25000;
    localparam int CONV_TIME_US = 28600;
    localparam int INTERVAL_01_US = 364000;
    localparam int INTERVAL_10_US = 1000000;
    localparam int INTERVAL_11_US = 2500000;
    localparam int CONV_CYCLES = CONV_TIME_US * (CLK_KHZ / 1000);
    localparam int INTERVAL_01_CYCLES = INTERVAL_01_US * (CLK_KHZ / 1000);
    localparam int INTERVAL_10_CYCLES = INTERVAL_10_US * (CLK_KHZ / 1000);
    localparam int INTERVAL_11_CYCLES = INTERVAL_11_US * (CLK_KHZ / 1000);
    localparam int TMR_W = 27;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tcs_req_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CONV,
        ST_WAIT
    } tcs_state_e;
endpackage : tcs_pkg

//--- tcs_host.sv
`timescale 1ns/1ns
module tcs_host (
    input wire logic clk,
    input wire logic [7:0] rdata,
    output tcs_pkg::tcs_req_s req
);
    initial req = '0;
    // Callers keep filter codes legal, never 2'h2
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 req = '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
        @(posedge clk);
        // Released lines flip so stale values never pass
        #1 req = '{wr: 1'h0, rd: 1'h0, addr: ~a, wdata: ~d};
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1 req = '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
        @(posedge clk);
        #1 req = '{wr: 1'h0, rd: 1'h0, addr: ~a, wdata: 8'hFF};
        d = rdata;
    endtask : rd
endmodule : tcs_host

//--- tcs_scheduler_chk.sv
`timescale 1ns/1ns
module tcs_scheduler_chk #(
    parameter int CONV_CYC = 10
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire tcs_pkg::tcs_req_s req,
    input wire logic [7:0] rdata,
    input wire logic conv_start,
    input wire logic [2:0] conv_chan,
    input wire logic busy,
    input wire logic standby,
    input wire logic remote1_ext_res,
    input wire logic remote2_ext_res
);
    localparam int HOLD = CONV_CYC - 1;
    logic wr_on;
    logic rd_on;
    assign wr_on = ce && req.wr;
    assign rd_on = ce && req.rd;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    AST_IN_PASS:
        assert property (conv_start |-> busy && conv_chan <= 3'h4)
        else $error("start outside pass");
    // Counter keeps the check short for any conversion length
    logic [31:0] left_r;
    always_ff @(posedge clk) begin
        if (srst) begin
            left_r <= 32'h0;
        end else if (ce) begin
            if (conv_start) begin
                left_r <= 32'(HOLD);
            end else if (left_r != 32'h0) begin
                left_r <= left_r - 32'h1;
            end
        end
    end
    AST_HOLD:
        assert property (left_r != 32'h0 |-> busy)
        else $error("pass ended inside conversion");
    // Gap of 8 assumes CONV_CYC of at least 9
    AST_GAP:
        assert property (conv_start |=> !conv_start [*8])
        else $error("starts too close");
    AST_ONESHOT:
        assert property (wr_on && req.addr == tcs_pkg::ADDR_TRIGGER &&
            standby && !busy |=> busy ##1 conv_start)
        else $error("trigger did not start a pass");
    AST_FILT1:
        assert property (wr_on && req.addr == tcs_pkg::ADDR_FILTER |=>
            remote1_ext_res == |$past(req.wdata[1:0]))
        else $error("remote1 resolution wrong");
    AST_FILT2:
        assert property (wr_on && req.addr == tcs_pkg::ADDR_FILTER |=>
            remote2_ext_res == |$past(req.wdata[3:2]))
        else $error("remote2 resolution wrong");
    AST_STANDBY_CTRL:
        assert property (wr_on && req.addr == tcs_pkg::ADDR_CONFIG |=>
            standby == $past(req.wdata[6]))
        else $error("standby not updated");
    AST_WO:
        assert property (rd_on && req.addr == tcs_pkg::ADDR_TRIGGER |=>
            rdata == 8'h00)
        else $error("trigger location readable");
endmodule : tcs_scheduler_chk
bind tcs_scheduler tcs_scheduler_chk #(.CONV_CYC(CONV_CYC)) chk_i (
    .clk(clk), .srst(srst), .ce(ce), .req(req), .rdata(rdata),
    .conv_start(conv_start), .conv_chan(conv_chan), .busy(busy),
    .standby(standby), .remote1_ext_res(remote1_ext_res),
    .remote2_ext_res(remote2_ext_res)
);

//--- tcs_scheduler_bench.sv
`timescale 1ns/1ns
module tcs_scheduler_bench;
    localparam int CC = 10;
    localparam int I01 = 200;
    logic clk;
    logic srst = 1'h1;
    logic ce = 1'h1;
    tcs_pkg::tcs_req_s req;
    logic [7:0] rdata;
    logic [7:0] d;
    logic cs;
    logic [2:0] ch;
    logic busy;
    logic stb;
    logic [1:0] ext;
    logic [1:0] fc [3] = '{2'h0, 2'h1, 2'h3};
    int n_fail;
    int n_tests;
    int cyc;
    int ns;
    int p;
    int q;
    // Short counts keep every interval test within a few thousand cycles
    tcs_scheduler #(.CONV_CYC(CC), .INT01_CYC(I01), .INT10_CYC(400),
        .INT11_CYC(800)) dut (.clk(clk), .srst(srst), .ce(ce), .req(req),
        .rdata(rdata), .conv_start(cs), .conv_chan(ch), .busy(busy),
        .standby(stb), .remote1_ext_res(ext[0]), .remote2_ext_res(ext[1]));
    tcs_host host (.clk(clk), .rdata(rdata), .req(req));
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        ns <= ns + int'(cs);
    end
    task automatic chk(input string s, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %0h seen %0h", s, e, g);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, d);
        chk("rdata", e, d);
    endtask : rchk
    // First span may straddle a setting change, so it is dropped
    task automatic per(input logic [2:0] c, output int r);
        int t [3];
        for (int i = 0; i < 3; i++) begin
            @(posedge clk iff (cs && ch == c));
            t[i] = cyc;
        end
        r = t[2] - t[1];
    endtask : per
    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test
    initial begin
        #(40 * 50000);
        n_fail++;
        stop_test();
    end
    initial begin
        repeat (4) @(posedge clk);
        #1 srst = 1'h0;
        chk("ext", 2'h3, ext);
        rchk(8'h04, 8'h02);
        rchk(8'h05, 8'h1F);
        rchk(8'h06, 8'h0F);
        rchk(8'h03, 8'h00);
        for (int i = 4; i < 7; i++) begin
            host.wr(i[7:0], 8'hFF);
            rchk(i[7:0], i == 4 ? 8'h03 : 8'h1F >> (i - 5));
        end
        host.wr(8'h0F, 8'hA5);
        rchk(8'h0F, 8'h00);
        rchk(8'h20, 8'h00);
        for (int i = 0; i < 3; i++) begin
            d = {4'h0, fc[i], fc[(i + 1) % 3]};
            host.wr(8'h06, d);
            rchk(8'h06, {4'h0, fc[i], fc[(i + 1) % 3]});
            chk("ext", {fc[i] != 0, fc[(i + 1) % 3] != 0}, ext);
        end
        for (int i = 1; i < 4; i++) begin
            host.wr(8'h04, i[7:0]);
            per(3'h0, p);
            chk("period", I01 << (i - 1), p);
        end
        host.wr(8'h05, 8'h01);
        host.wr(8'h04, 8'h01);
        host.wr(8'h0F, 8'h00);
        per(3'h0, p);
        chk("period", I01, p);
        host.wr(8'h04, 8'h00);
        per(3'h0, q);
        host.wr(8'h05, 8'h1F);
        per(3'h0, p);
        // Each extra channel costs one slot of CC cycles
        chk("gap", 4 * CC, p - q);
        host.wr(8'h03, 8'h40);
        chk("standby", 1, stb);
        while (busy) @(posedge clk);
        host.wr(8'h05, 8'h1A);
        q = ns;
        host.wr(8'h0F, 8'h5A);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk iff cs);
            chk("chan", i == 0 ? 1 : i + 2, ch);
        end
        repeat (300) @(posedge clk);
        chk("starts", 3, ns - q);
        // Write while frozen must not land
        #1 ce = 1'h0;
        host.wr(8'h04, 8'h03);
        ce = 1'h1;
        rchk(8'h04, 8'h00);
        stop_test();
    end
endmodule : tcs_scheduler_bench
